// ===== logic/drm_diag_readback.sv
// Overview of operation
// RL1: Hold bit 0 keeps results refreshing; hold bit 1 freezes them.
// RL2: Writable override bit enables supply/temperature substitution when set.
// RL3: Each point's upper result byte reads in bits 7-0, reset zero.
// RL4: Each point's lower nibble reads in bits 7-4, reset zero.
// RL5: Battery lower register tag bits 3-0 read 0000b.
// RL6: Mic bias lower register tag bits 3-0 read 0001b.
// RL7: Input 1 positive leg tag bits 3-0 read 0010b.
// RL8: Input 1 negative leg tag bits 3-0 read 0011b.
// RL9: Input 2 positive leg tag bits 3-0 read 0100b.
// RL10: Software writes zero to config bits 7-2; they read as zero.
// RL11: Byte and nibble update together from one 12-bit result.
`timescale 1ns/1ns
`default_nettype none
module drm_diag_readback (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic [drm_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic reg_wr_en_in,
  input wire logic [drm_pkg::DATA_W-1:0] reg_wdata_in,
  input wire logic reg_rd_en_in,
  output logic [drm_pkg::DATA_W-1:0] reg_rdata_out,
  input wire logic sample_valid_in,
  input wire logic [drm_pkg::TAG_W-1:0] sample_tag_in,
  input wire logic [drm_pkg::RESULT_W-1:0] sample_data_in,
  output logic freeze_result_update_out,
  output logic supply_temp_result_substitute_out
);
  import drm_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic freeze_result_update;
    logic supply_temp_result_substitute;
    logic [7:0] rdata;
  } drm_top_state_t;

  drm_top_state_t st_q;
  drm_top_state_t st_d;
  logic rstn_sync;
  logic [7:0] high_bytes [NUM_POINTS];
  logic [7:0] low_bytes [NUM_POINTS];
  logic [7:0] cfg_read;
  logic [7:0] read_mux;

  drm_reset_sync u_reset_sync (
    .core_clk_in(core_clk_in),
    .rstn_in(rstn_in),
    .rstn_sync_out(rstn_sync)
  );

  // ----------------------------------------
  // Result slots, tags 0..4 in point order
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_POINTS; gi++) begin : g_point
      drm_result_slot #(
        .CHANNEL_TAG(POINT_TAGS[gi*TAG_W +: TAG_W]) // see RL5 see RL6 see RL7 see RL8 see RL9
      ) u_slot (
        .core_clk_in(core_clk_in),
        .rstn_in(rstn_sync),
        .sample_valid_in(sample_valid_in),
        .sample_tag_in(sample_tag_in),
        .sample_data_in(sample_data_in),
        .freeze_in(st_q.freeze_result_update), // see RL1
        .result_high_out(high_bytes[gi]),
        .result_low_out(low_bytes[gi])
      );
    end
  endgenerate

  // Read decode below serves exactly five points
  if ((NUM_POINTS != 5) ||
      ($bits(POINT_TAGS) != NUM_POINTS * TAG_W)) begin : g_bad_points
    $error("point count and tag table do not match the read decode");
  end

  // ----------------------------------------
  // Read decode
  // ----------------------------------------
  always_comb begin
    cfg_read = 8'h00; // see RL10
    cfg_read[POS_FREEZE_RESULT_UPDATE] = st_q.freeze_result_update;
    cfg_read[POS_SUPPLY_TEMP_RESULT_SUBSTITUTE] =
      st_q.supply_temp_result_substitute;
    case (reg_addr_in)
      OFS_DIAG_RESULT_CONFIG: read_mux = cfg_read;
      OFS_BATTERY_RESULT_HIGH: read_mux = high_bytes[0];
      OFS_BATTERY_RESULT_LOW: read_mux = low_bytes[0];
      OFS_MIC_BIAS_RESULT_HIGH: read_mux = high_bytes[1];
      OFS_MIC_BIAS_RESULT_LOW: read_mux = low_bytes[1];
      OFS_INPUT1_POS_RESULT_HIGH: read_mux = high_bytes[2];
      OFS_INPUT1_POS_RESULT_LOW: read_mux = low_bytes[2];
      OFS_INPUT1_NEG_RESULT_HIGH: read_mux = high_bytes[3];
      OFS_INPUT1_NEG_RESULT_LOW: read_mux = low_bytes[3];
      OFS_INPUT2_POS_RESULT_HIGH: read_mux = high_bytes[4];
      OFS_INPUT2_POS_RESULT_LOW: read_mux = low_bytes[4];
      default: read_mux = READ_UNMAPPED;
    endcase
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_d = st_q;
    // Only bits 1:0 are stored; upper bits are dropped on write
    if (reg_wr_en_in && (reg_addr_in == OFS_DIAG_RESULT_CONFIG)) begin
      st_d.freeze_result_update =
        reg_wdata_in[POS_FREEZE_RESULT_UPDATE]; // see RL1
      st_d.supply_temp_result_substitute =
        reg_wdata_in[POS_SUPPLY_TEMP_RESULT_SUBSTITUTE]; // see RL2
    end
    // Read data holds until the next read strobe
    if (reg_rd_en_in) begin
      st_d.rdata = read_mux;
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_sync) begin
    if (!rstn_sync) begin
      st_q.freeze_result_update <=
        RST_DIAG_RESULT_CONFIG[POS_FREEZE_RESULT_UPDATE];
      st_q.supply_temp_result_substitute <=
        RST_DIAG_RESULT_CONFIG[POS_SUPPLY_TEMP_RESULT_SUBSTITUTE];
      st_q.rdata <= READ_UNMAPPED;
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata_out = st_q.rdata;
  assign freeze_result_update_out = st_q.freeze_result_update;
  assign supply_temp_result_substitute_out =
    st_q.supply_temp_result_substitute; // see RL2
endmodule : drm_diag_readback
`default_nettype wire

// ===== logic/drm_pkg.sv
`default_nettype none
package drm_pkg;
  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned RESULT_W = 12;
  localparam int unsigned TAG_W = 4;
  localparam int unsigned NUM_POINTS = 5;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_DIAG_RESULT_CONFIG = 8'h55;
  localparam logic [7:0] OFS_BATTERY_RESULT_HIGH = 8'h56;
  localparam logic [7:0] OFS_BATTERY_RESULT_LOW = 8'h57;
  localparam logic [7:0] OFS_MIC_BIAS_RESULT_HIGH = 8'h58;
  localparam logic [7:0] OFS_MIC_BIAS_RESULT_LOW = 8'h59;
  localparam logic [7:0] OFS_INPUT1_POS_RESULT_HIGH = 8'h5A;
  localparam logic [7:0] OFS_INPUT1_POS_RESULT_LOW = 8'h5B;
  localparam logic [7:0] OFS_INPUT1_NEG_RESULT_HIGH = 8'h5C;
  localparam logic [7:0] OFS_INPUT1_NEG_RESULT_LOW = 8'h5D;
  localparam logic [7:0] OFS_INPUT2_POS_RESULT_HIGH = 8'h5E;
  localparam logic [7:0] OFS_INPUT2_POS_RESULT_LOW = 8'h5F;

  // ----------------------------------------
  // Configuration fields and reset values
  // ----------------------------------------
  localparam int unsigned POS_FREEZE_RESULT_UPDATE = 0;
  localparam int unsigned POS_SUPPLY_TEMP_RESULT_SUBSTITUTE = 1;
  localparam logic [7:0] RST_DIAG_RESULT_CONFIG = 8'h00;
  localparam logic [7:0] RST_RESULT_HIGH = 8'h00;
  localparam logic [3:0] RST_RESULT_NIBBLE = 4'h0;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // ----------------------------------------
  // Channel tags, indexed by point
  // ----------------------------------------
  localparam logic [3:0] TAG_BATTERY_SENSE_POINT = 4'h0;
  localparam logic [3:0] TAG_MIC_BIAS = 4'h1;
  localparam logic [3:0] TAG_INPUT1_POSITIVE_LEG = 4'h2;
  localparam logic [3:0] TAG_INPUT1_NEGATIVE_LEG = 4'h3;
  localparam logic [3:0] TAG_INPUT2_POSITIVE_LEG = 4'h4;
  localparam logic [19:0] POINT_TAGS = {TAG_INPUT2_POSITIVE_LEG,
    TAG_INPUT1_NEGATIVE_LEG, TAG_INPUT1_POSITIVE_LEG, TAG_MIC_BIAS,
    TAG_BATTERY_SENSE_POINT};
endpackage : drm_pkg
`default_nettype wire

// ===== logic/drm_reset_sync.sv
`timescale 1ns/1ns
`default_nettype none
module drm_reset_sync (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  output logic rstn_sync_out
);
  typedef struct packed {
    logic stage1;
    logic stage2;
  } drm_rsync_state_t;

  drm_rsync_state_t st_q;
  drm_rsync_state_t st_d;

  always_comb begin
    st_d = st_q;
    st_d.stage1 = 1'b1;
    st_d.stage2 = st_q.stage1;
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign rstn_sync_out = st_q.stage2;
endmodule : drm_reset_sync
`default_nettype wire

// ===== logic/drm_result_slot.sv
`timescale 1ns/1ns
`default_nettype none
module drm_result_slot #(
  parameter logic [3:0] CHANNEL_TAG = 4'h0
) (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic sample_valid_in,
  input wire logic [3:0] sample_tag_in,
  input wire logic [11:0] sample_data_in,
  input wire logic freeze_in,
  output logic [7:0] result_high_out,
  output logic [7:0] result_low_out
);
  import drm_pkg::*;

  typedef struct packed {
    logic [11:0] result;
  } drm_slot_state_t;

  drm_slot_state_t st_q;
  drm_slot_state_t st_d;

  always_comb begin
    st_d = st_q;
    // Whole 12-bit word in one edge so byte and nibble never tear
    if (sample_valid_in && (sample_tag_in == CHANNEL_TAG) && !freeze_in) begin
      st_d.result = sample_data_in; // see RL1 see RL11
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_q.result <= {RST_RESULT_HIGH, RST_RESULT_NIBBLE};
    end else begin
      st_q <= st_d;
    end
  end

  assign result_high_out = st_q.result[11:4]; // see RL3
  assign result_low_out = {st_q.result[3:0], CHANNEL_TAG}; // see RL4
endmodule : drm_result_slot
`default_nettype wire

// ===== tb/drm_props.sv
`timescale 1ns/1ns
`default_nettype none
module drm_props (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_en_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_rd_en_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic sample_valid_in,
  input wire logic [3:0] sample_tag_in,
  input wire logic [11:0] sample_data_in,
  input wire logic freeze_result_update_out,
  input wire logic supply_temp_result_substitute_out
);
  // ------
  // Checks
  // ------
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);
  wire logic [7:0] a = reg_addr_in;
  wire logic [7:0] q = reg_rdata_out;
  wire logic r = reg_rd_en_in;
  wire logic w = reg_wr_en_in && a == 8'h55;
  wire logic [1:0] c = {supply_temp_result_substitute_out,
    freeze_result_update_out};
  sequence s_cap(logic [7:0] ad);
    sample_valid_in && !c[0] && sample_tag_in == 4'h0 ##1
      !sample_valid_in ##1 r && a == ad;
  endsequence
  property p_frz; w |=> c[0] == $past(reg_wdata_in[0]); endproperty
  a_frz: assert property (p_frz) else $error("hold bit");
  property p_ovr; w |=> c[1] == $past(reg_wdata_in[1]); endproperty
  a_ovr: assert property (p_ovr) else $error("override bit");
  property p_keep; !w |=> $stable(c); endproperty
  a_keep: assert property (p_keep) else $error("config moved");
  property p_cfg; r && a == 8'h55 |=> q == {6'h00, $past(c)}; endproperty
  a_cfg: assert property (p_cfg) else $error("config read");
  property p_tag; r && a[0] && a > 8'h56 && a < 8'h60 |=>
    q[3:0] == 4'(($past(a) - 8'h57) >> 1); endproperty
  a_tag: assert property (p_tag) else $error("channel tag");
  property p_hold; !r |=> $stable(q); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_hi; s_cap(8'h56) |=> q == $past(sample_data_in[11:4], 3);
  endproperty
  a_hi: assert property (p_hi) else $error("high byte");
  property p_lo; s_cap(8'h57) |=> q[7:4] == $past(sample_data_in[3:0], 3);
  endproperty
  a_lo: assert property (p_lo) else $error("low nibble");
endmodule : drm_props
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic core_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00;
  logic reg_wr_en_in = 1'b0;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_rd_en_in = 1'b0;
  logic [7:0] reg_rdata_out;
  logic sample_valid_in = 1'b0;
  logic [3:0] sample_tag_in = 4'h0;
  logic [11:0] sample_data_in = 12'h000;
  logic freeze_result_update_out;
  logic supply_temp_result_substitute_out;
  wire logic [7:0] cf = {6'h00, supply_temp_result_substitute_out,
    freeze_result_update_out};
  logic [11:0] v [5];
  int err_count = 0;
  int checks_done = 0;
  always #25 core_clk_in = ~core_clk_in;
  drm_diag_readback u_drm_diag_readback (.core_clk_in, .rstn_in,
    .reg_addr_in, .reg_wr_en_in, .reg_wdata_in, .reg_rd_en_in,
    .reg_rdata_out, .sample_valid_in, .sample_tag_in, .sample_data_in,
    .freeze_result_update_out, .supply_temp_result_substitute_out);
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  // Idle cycle after each strobe keeps drivers single per step
  task automatic step();
    @(negedge core_clk_in);
    reg_wr_en_in = 1'b0;
    reg_rd_en_in = 1'b0;
    sample_valid_in = 1'b0;
    @(negedge core_clk_in);
  endtask : step
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    reg_addr_in = ad;
    reg_wdata_in = d;
    reg_wr_en_in = 1'b1;
    step();
  endtask : wr
  task automatic rd(input logic [7:0] ad, input logic [7:0] e);
    reg_addr_in = ad;
    reg_rd_en_in = 1'b1;
    step();
    chk(reg_rdata_out, e);
  endtask : rd
  task automatic smp(input logic [3:0] t, input logic [11:0] d);
    sample_tag_in = t;
    sample_data_in = d;
    sample_valid_in = 1'b1;
    step();
  endtask : smp
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test
  // -----
  // Tests
  // -----
  initial begin
    repeat (3) @(negedge core_clk_in);
    rstn_in = 1'b1;
    repeat (3) @(negedge core_clk_in);
    for (int i = 0; i < 5; i++) begin
      v[i] = 12'h9C3 ^ 12'(i * 12'h111);
      rd(8'(8'h56 + 2 * i), 8'h00);
      rd(8'(8'h57 + 2 * i), 8'(i));
    end
    rd(8'h55, 8'h00);
    rd(8'h60, 8'h00);
    $display("test 1 done");
    wr(8'h55, 8'h03);
    chk(cf, 8'h03);
    rd(8'h55, 8'h03);
    wr(8'h55, 8'h00);
    chk(cf, 8'h00);
    $display("test 2 done");
    for (int i = 0; i < 5; i++) smp(4'(i), v[i]);
    for (int i = 0; i < 5; i++) begin
      rd(8'(8'h56 + 2 * i), v[i][11:4]);
      rd(8'(8'h57 + 2 * i), {v[i][3:0], 4'(i)});
    end
    $display("test 3 done");
    wr(8'h55, 8'h01);
    smp(4'h0, 12'h5A7);
    rd(8'h56, v[0][11:4]);
    wr(8'h55, 8'h00);
    smp(4'h0, 12'h5A7);
    rd(8'h56, 8'h5A);
    smp(4'h0, 12'h3B6);
    rd(8'h57, 8'h60);
    smp(4'hF, 12'hFFF);
    rd(8'h5F, {v[4][3:0], 4'h4});
    $display("test 4 done");
    end_of_test();
  end
  initial begin
    #20000;
    err_count++;
    $display("[ERR] %0t watchdog", $time);
    end_of_test();
  end
endmodule : tb
bind drm_diag_readback drm_props u_drm_props (.core_clk_in, .rstn_in,
  .reg_addr_in, .reg_wr_en_in, .reg_wdata_in, .reg_rd_en_in,
  .reg_rdata_out, .sample_valid_in, .sample_tag_in, .sample_data_in,
  .freeze_result_update_out, .supply_temp_result_substitute_out);
`default_nettype wire
